// ===== dss_pkg.sv
/*
 * Package of constants and carrier types for the dual output startup sequencer.
 * Assumes a single 25 MHz clock and a synchronous active-low reset taken as power-on.
 */
// Operation
// R1 - Sample three-state select once at power-on
// R2 - Output 2 leads, output 1 follows 400 us
// R3 - Output 1 leads, output 2 follows 400 us
// R4 - Leader disabled: both outputs off at once
// R5 - Trailing enable ignored while leader enabled
// R6 - Outside holds trailing enable for bias state
// R7 - Tied enables ramp both outputs together
// R8 - Floating select: channels fully independent
// R9 - Disable: upper switch off, pulldown stays off
// R10 - Stepped soft start 0 to 0.8 V, 2.1 ms
// R11 - Current limiting active during soft start
// R12 - Overcurrent in soft start skips six pulses
// R13 - No skipping without a current-limit pulse
// R14 - Undervoltage at soft start end forces hiccup
// R15 - Enables active low, undriven reads inactive
// R16 - Both enables inactive: shutdown, bias off
// R17 - Channels alternate, oscillator at twice switching
// R18 - Regulation at ramp end; delay by counter
package dss_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int SEQ_DELAY_US = 400;
    localparam int SEQ_DELAY_CYC = (SEQ_DELAY_US * (CLK_HZ / 1000000));
    localparam int SS_TIME_US = 2100;
    localparam int SS_TIME_CYC = (SS_TIME_US * (CLK_HZ / 1000000));
    localparam int SS_STEPS = 64;
    localparam int SS_STEP_CYC = SS_TIME_CYC / SS_STEPS;
    localparam int OSC_DIV = 42;
    localparam int SKIP_PULSES = 6;
    localparam int CNT_W = 16;

    // ==========================================================
    // Reference code: 0.8 V full scale in 10-bit steps of 1 mV.
    localparam int REF_W = 10;
    localparam logic [REF_W-1:0] REF_FINAL = 10'h320;
    localparam logic [REF_W-1:0] REF_STEP = 10'h00d;

    // ==========================================================
    // Decoded sequence modes, one-hot.
    typedef enum logic [2:0] {
        DSS_MODE_IND = 3'h1,
        DSS_MODE_2F = 3'h2,
        DSS_MODE_1F = 3'h4
    } dss_mode_t;

    // Three-state select pin, as two comparator levels.
    typedef struct packed {
        logic high;
        logic low;
    } dss_sel_t;

    // Per-channel soft start states, one-hot.
    typedef enum logic [3:0] {
        DSS_CH_OFF = 4'h1,
        DSS_CH_RAMP = 4'h2,
        DSS_CH_REG = 4'h4,
        DSS_CH_HICCUP = 4'h8
    } dss_ch_state_t;

    // Per-channel status.
    typedef struct packed {
        logic upper_switch_on;
        logic pulldown_on;
        logic soft_start;
        logic current_limit_on;
        logic regulating;
        logic [REF_W-1:0] reference;
    } dss_ch_out_t;

endpackage

// ===== dss_sync.sv
/*
 * Three-stage input synchroniser; the output changes once stages two and three agree.
 * Assumes an asynchronous input and the common clock.
 */
`timescale 1ns/10ps
`default_nettype none
module dss_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    input wire logic init,
    output logic dout
);
    import dss_pkg::*;

    typedef struct packed {
        logic [2:0] stage;
        logic q;
    } dss_sync_st_t;

    dss_sync_st_t st_r;
    dss_sync_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.stage = {st_r.stage[1:0], din};
        if (st_r.stage[1] == st_r.stage[2]) begin
            st_nxt.q = st_r.stage[2];
        end
    end

    // Reset loads the pin's idle level so no false change follows reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '{stage: {3{init}}, q: init};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.q;

    AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.stage[1] == st_r.stage[2]) |=> (dout == $past(st_r.stage[2])))
        else $error("synchroniser output ignored agreeing stages");
endmodule
`default_nettype wire

// ===== dss_channel.sv
/*
 * One output channel: soft start ramp, pulse gating and current-limit skipping.
 * Assumes a phase strobe from the shared oscillator and synchronised comparator inputs.
 */
`timescale 1ns/10ps
`default_nettype none
module dss_channel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic phase_tick,
    input wire logic overcurrent,
    input wire logic undervoltage,
    output dss_pkg::dss_ch_out_t status,
    output logic pwm_pulse
);
    import dss_pkg::*;

    typedef struct packed {
        dss_ch_state_t state;
        logic [CNT_W-1:0] step_cnt;
        logic [6:0] step_idx;
        logic [2:0] skip_cnt;
        logic [REF_W-1:0] ref_code;
        logic pulse;
    } dss_ch_st_t;

    dss_ch_st_t st_r;
    dss_ch_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.pulse = 1'b0;
        case (st_r.state)
            DSS_CH_OFF: begin
                st_nxt.ref_code = '0;
                st_nxt.step_cnt = '0;
                st_nxt.step_idx = '0;
                st_nxt.skip_cnt = '0;
                if (run) begin
                    st_nxt.state = DSS_CH_RAMP;
                end
            end
            DSS_CH_RAMP: begin
                // Stepped reference climb to the final value.
                if (st_r.step_cnt == CNT_W'(SS_STEP_CYC - 1)) begin // R10
                    st_nxt.step_cnt = '0;
                    st_nxt.step_idx = st_r.step_idx + 1'b1;
                    // The code saturates a little early; all steps still run so the ramp time stays fixed.
                    if (st_r.ref_code >= REF_FINAL - REF_STEP) begin
                        st_nxt.ref_code = REF_FINAL;
                    end else begin
                        st_nxt.ref_code = st_r.ref_code + REF_STEP;
                    end
                    if (st_r.step_idx == 7'(SS_STEPS - 1)) begin // R10
                        st_nxt.ref_code = REF_FINAL;
                        // Still under voltage at ramp end: restart the output.
                        st_nxt.state = undervoltage ? DSS_CH_HICCUP : DSS_CH_REG; // R14
                    end
                end else begin
                    st_nxt.step_cnt = st_r.step_cnt + 1'b1;
                end
                // Skip only after a detected limit pulse, six phase slots.
                if (phase_tick) begin
                    if (st_r.skip_cnt != '0) begin // R13
                        st_nxt.skip_cnt = st_r.skip_cnt - 1'b1; // R12
                    end else begin
                        st_nxt.pulse = 1'b1;
                    end
                end
                if (overcurrent && st_r.skip_cnt == '0) begin // R11
                    st_nxt.skip_cnt = 3'(SKIP_PULSES); // R12
                end
            end
            DSS_CH_REG: begin
                st_nxt.pulse = phase_tick && !overcurrent; // R11
            end
            DSS_CH_HICCUP: begin
                st_nxt.state = DSS_CH_OFF;
            end
            default: begin
                st_nxt.state = DSS_CH_OFF;
            end
        endcase
        // Disable wins in every state.
        if (!run) begin // R9
            st_nxt.state = DSS_CH_OFF;
            st_nxt.pulse = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '{state: DSS_CH_OFF, step_cnt: '0, step_idx: '0, skip_cnt: '0, ref_code: '0, pulse: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        status.upper_switch_on = st_r.pulse; // R9
        status.pulldown_on = 1'b0; // R9
        status.soft_start = (st_r.state == DSS_CH_RAMP);
        status.current_limit_on = (st_r.state == DSS_CH_RAMP) || (st_r.state == DSS_CH_REG); // R11
        status.regulating = (st_r.state == DSS_CH_REG);
        status.reference = st_r.ref_code;
    end
    assign pwm_pulse = st_r.pulse;

    sequence s_limit_hit;
        (st_r.state == DSS_CH_RAMP) && overcurrent && run && st_r.skip_cnt == '0;
    endsequence
    AST_SKIP_SIX: assert property (@(posedge clk) disable iff (!rst_n) // R12
        s_limit_hit |=> (st_r.skip_cnt == 3'(SKIP_PULSES)))
        else $error("overcurrent did not load six skips");
    AST_NO_SKIP: assert property (@(posedge clk) disable iff (!rst_n) // R13
        (st_r.state == DSS_CH_RAMP) && run && phase_tick && st_r.skip_cnt == '0 |=> pwm_pulse)
        else $error("pulse skipped without current limit");
    AST_OFF_DROPS: assert property (@(posedge clk) disable iff (!rst_n) // R9
        !run |=> !pwm_pulse && status.pulldown_on == 1'b0)
        else $error("switch still on after disable");
    AST_REF_CAP: assert property (@(posedge clk) disable iff (!rst_n) // R10
        status.regulating |-> status.reference == REF_FINAL)
        else $error("reference not at final value in regulation");
endmodule
`default_nettype wire

// ===== dss_sequencer.sv
/*
 * Top of the dual output startup sequencer: select strap capture, enable handling,
 * inter-channel delay, shutdown decision and the alternating phase oscillator.
 * Assumes enables and the select comparators arrive asynchronously from the board.
 */
`timescale 1ns/10ps
`default_nettype none
module dss_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire dss_pkg::dss_sel_t sequence_select,
    input wire logic enable_ch1_n,
    input wire logic enable_ch2_n,
    input wire logic overcurrent_ch1,
    input wire logic overcurrent_ch2,
    input wire logic output_undervoltage_ch1,
    input wire logic output_undervoltage_ch2,
    output dss_pkg::dss_mode_t mode,
    output logic bias_regulator_on,
    output logic shutdown,
    output dss_pkg::dss_ch_out_t status_ch1,
    output dss_pkg::dss_ch_out_t status_ch2,
    output logic pwm_ch1,
    output logic pwm_ch2
);
    import dss_pkg::*;

    // Both comparator levels high cannot come from the pin, so it marks an unfilled chain.
    localparam logic [1:0] SEL_NONE = 2'h3;

    // ==========================================================
    // State
    typedef struct packed {
        logic captured;
        dss_mode_t mode;
        logic [CNT_W-1:0] delay_cnt;
        logic follow_go;
        logic [5:0] osc_cnt;
        logic phase;
        logic tick;
        logic [1:0] sel_sync_a;
        logic [1:0] sel_sync_b;
        logic [1:0] sel_sync_c;
    } dss_top_st_t;

    dss_top_st_t st_r;
    dss_top_st_t st_nxt;

    logic en1_n;
    logic en2_n;
    logic run1;
    logic run2;
    logic lead_en;
    logic lead_reg;
    dss_ch_out_t s1;
    dss_ch_out_t s2;

    // Three-level strap decode, used only for the capture.
    function automatic dss_mode_t decode_sel(input logic [1:0] lv);
        if (lv[1]) begin
            return DSS_MODE_2F;
        end else if (lv[0]) begin
            return DSS_MODE_1F;
        end else begin
            return DSS_MODE_IND;
        end
    endfunction

    dss_sync u_en1 (
        .clk(clk),
        .rst_n(rst_n),
        .din(enable_ch1_n),
        .init(1'b1),
        .dout(en1_n)
    );
    dss_sync u_en2 (
        .clk(clk),
        .rst_n(rst_n),
        .din(enable_ch2_n),
        .init(1'b1),
        .dout(en2_n)
    );

    // ==========================================================
    // Leader and follower selection
    always_comb begin
        lead_en = 1'b0;
        lead_reg = 1'b0;
        run1 = 1'b0;
        run2 = 1'b0;
        case (st_r.mode)
            DSS_MODE_2F: begin
                lead_en = !en2_n;
                lead_reg = s2.regulating;
                run2 = !en2_n; // R2
                // Follower enable is not looked at; leader drop kills both.
                run1 = !en2_n && st_r.follow_go; // R4 R5
            end
            DSS_MODE_1F: begin
                lead_en = !en1_n;
                lead_reg = s1.regulating;
                run1 = !en1_n; // R3
                run2 = !en1_n && st_r.follow_go; // R4 R5
            end
            default: begin
                // Tied enables start both ramps together and they finish together.
                run1 = !en1_n; // R7 R8 R15
                run2 = !en2_n; // R7 R8 R15
            end
        endcase
        if (!st_r.captured) begin
            run1 = 1'b0;
            run2 = 1'b0;
        end
    end

    // ==========================================================
    // Sequencing and oscillator
    always_comb begin
        st_nxt = st_r;
        st_nxt.sel_sync_a = {sequence_select.high, sequence_select.low};
        st_nxt.sel_sync_b = st_r.sel_sync_a;
        st_nxt.sel_sync_c = st_r.sel_sync_b;
        // Captured once, after the strap has settled; later changes are ignored.
        if (!st_r.captured && st_r.sel_sync_b == st_r.sel_sync_c && st_r.sel_sync_c != SEL_NONE) begin // R1
            st_nxt.captured = 1'b1;
            st_nxt.mode = decode_sel(st_r.sel_sync_c); // R1
        end
        // Delay counted from the leader reaching regulation.
        if (!lead_en) begin // R4
            st_nxt.delay_cnt = '0;
            st_nxt.follow_go = 1'b0;
        end else if (lead_reg && !st_r.follow_go) begin // R18
            if (st_r.delay_cnt == CNT_W'(SEQ_DELAY_CYC - 1)) begin // R2 R3
                st_nxt.follow_go = 1'b1;
            end else begin
                st_nxt.delay_cnt = st_r.delay_cnt + 1'b1;
            end
        end
        // Oscillator at twice the switching rate; each tick alternates channels.
        st_nxt.tick = 1'b0;
        if (st_r.osc_cnt == 6'(OSC_DIV - 1)) begin // R17
            st_nxt.osc_cnt = '0;
            st_nxt.tick = 1'b1;
            st_nxt.phase = !st_r.phase; // R17
        end else begin
            st_nxt.osc_cnt = st_r.osc_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '{captured: 1'b0, mode: DSS_MODE_IND, delay_cnt: '0, follow_go: 1'b0,
                      osc_cnt: '0, phase: 1'b0, tick: 1'b0, sel_sync_a: SEL_NONE, sel_sync_b: SEL_NONE,
                      sel_sync_c: SEL_NONE};
        end else begin
            st_r <= st_nxt;
        end
    end

    dss_channel u_ch1 (
        .clk(clk),
        .rst_n(rst_n),
        .run(run1),
        .phase_tick(st_r.tick && !st_r.phase),
        .overcurrent(overcurrent_ch1),
        .undervoltage(output_undervoltage_ch1),
        .status(s1),
        .pwm_pulse(pwm_ch1)
    );
    dss_channel u_ch2 (
        .clk(clk),
        .rst_n(rst_n),
        .run(run2),
        .phase_tick(st_r.tick && st_r.phase),
        .overcurrent(overcurrent_ch2),
        .undervoltage(output_undervoltage_ch2),
        .status(s2),
        .pwm_pulse(pwm_ch2)
    );

    // The trailing enable still powers the bias rail while the leader is off.
    assign shutdown = en1_n && en2_n; // R16 R6
    assign bias_regulator_on = !shutdown; // R16
    assign mode = st_r.mode;
    assign status_ch1 = s1;
    assign status_ch2 = s2;

    // ==========================================================
    // Checks
    AST_MODE_STICKS: assert property (@(posedge clk) disable iff (!rst_n) // R1
        st_r.captured |=> st_r.captured && $stable(st_r.mode))
        else $error("sequence mode changed after capture");
    AST_LEAD_DROP: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (st_r.mode != DSS_MODE_IND) && !lead_en |-> !run1 && !run2)
        else $error("outputs kept running after leader disable");
    AST_FOLLOW_WAIT: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (st_r.mode == DSS_MODE_2F) && $rose(s2.regulating) |-> !run1)
        else $error("follower started before delay");
    AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!rst_n) // R16
        en1_n && en2_n |-> !bias_regulator_on)
        else $error("bias on with both enables inactive");
    AST_NO_OVERLAP: assert property (@(posedge clk) disable iff (!rst_n) // R17
        !(pwm_ch1 && pwm_ch2))
        else $error("both channels pulsed together");
endmodule
`default_nettype wire

// ===== dss_board_model.sv
/*
 * Board-side model: the two enable drivers and the select strap.
 * Assumes the bench changes its commands at the rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module dss_board_model (
    input wire logic [1:0] strap,
    input wire logic drive1,
    input wire logic drive2,
    input wire logic tie_en,
    output dss_pkg::dss_sel_t sel,
    output logic en1_n,
    output logic en2_n
);
    import dss_pkg::*;
    // ==========================================================
    // Strap: 0 floating, 1 ground, 2 bias rail.
    assign sel = '{high: (strap == 2'h2), low: (strap == 2'h1)};
    // ==========================================================
    // Enables: a released pin is pulled to the inactive high level.
    assign en1_n = drive1 ? 1'b0 : 1'b1;
    // Tied pins follow each other for a common start.
    assign en2_n = tie_en ? en1_n : (drive2 ? 1'b0 : 1'b1);
endmodule
`default_nettype wire

// ===== dss_sequencer_tb_top.sv
/*
 * Self-checking bench for the startup sequencer with a board model.
 * Assumes register outputs, so values read at a rising edge are settled.
 */
`timescale 1ns/10ps
`default_nettype none
module dss_sequencer_tb_top;
    import dss_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] strap = 2'h0;
    logic drive1 = 1'b0;
    logic drive2 = 1'b0;
    logic tie_en = 1'b0;
    logic oc1 = 1'b0;
    logic oc2 = 1'b0;
    logic uv1 = 1'b0;
    logic uv2 = 1'b0;
    dss_sel_t sel;
    logic en1_n;
    logic en2_n;
    dss_mode_t mode;
    logic bias_on;
    logic shut;
    dss_ch_out_t st1;
    dss_ch_out_t st2;
    logic pwm1;
    logic pwm2;
    int n_mismatch = 0;
    int tests_run = 0;
    int k;
    int c;
    // ==========================================================
    // Clock and instances
    always #20 clk = ~clk;
    dss_board_model brd_u (.strap(strap), .drive1(drive1), .drive2(drive2),
        .tie_en(tie_en), .sel(sel), .en1_n(en1_n), .en2_n(en2_n));
    dss_sequencer dut_u (.clk(clk), .rst_n(rst_n), .sequence_select(sel),
        .enable_ch1_n(en1_n), .enable_ch2_n(en2_n), .overcurrent_ch1(oc1),
        .overcurrent_ch2(oc2), .output_undervoltage_ch1(uv1),
        .output_undervoltage_ch2(uv2), .mode(mode), .bias_regulator_on(bias_on),
        .shutdown(shut), .status_ch1(st1), .status_ch2(st2), .pwm_ch1(pwm1),
        .pwm_ch2(pwm2));
    // ==========================================================
    // Helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic count_pwm(input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            @(posedge clk);
            if (pwm1 === 1'b1) cnt++;
        end
    endtask
    // The strap is only read at power-on, so every mode needs a reset.
    task automatic restart(input logic [1:0] s);
        rst_n <= 1'b0;
        drive1 <= 1'b0;
        drive2 <= 1'b0;
        tie_en <= 1'b0;
        strap <= s;
        cyc(20);
        rst_n <= 1'b1;
        cyc(8);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_float;
        restart(2'h0);
        check("mode", mode, DSS_MODE_IND);
        check("shutdown", shut, 1'b1);
        check("bias", bias_on, 1'b0);
        strap <= 2'h2;
        cyc(10);
        check("mode kept", mode, DSS_MODE_IND);
    endtask
    task automatic t_indep;
        drive1 <= 1'b1;
        for (k = 0; k < 12 && st1.soft_start !== 1'b1; k++) cyc(1);
        check("ss1", st1.soft_start, 1'b1);
        check("limit1", st1.current_limit_on, 1'b1);
        check("ss2", st2.soft_start, 1'b0);
        check("bias", bias_on, 1'b1);
        for (k = 0; k < 100 && pwm1 !== 1'b1; k++) cyc(1);
        count_pwm(840, c);
        check("pulses", c, 10);
        for (k = 0; k < 100 && pwm1 !== 1'b1; k++) cyc(1);
        cyc(10);
        oc1 <= 1'b1;
        cyc(1);
        oc1 <= 1'b0;
        count_pwm(530, c);
        check("skipped", c, 0);
        count_pwm(84, c);
        check("resumed", c, 1);
        drive1 <= 1'b0;
        cyc(8);
        check("upper1", st1.upper_switch_on, 1'b0);
        check("pulldown1", st1.pulldown_on, 1'b0);
        check("shutdown", shut, 1'b1);
    endtask
    task automatic t_ratio;
        tie_en <= 1'b1;
        drive1 <= 1'b1;
        for (k = 0; k < 12 && st1.soft_start !== 1'b1; k++) cyc(1);
        check("ss2 with ss1", st2.soft_start, 1'b1);
        repeat (6) begin
            cyc(500);
            check("ref match", st2.reference, st1.reference);
        end
        for (k = 0; k < 100 && pwm1 !== 1'b1; k++) cyc(1);
        for (k = 0; k < 100 && pwm2 !== 1'b1; k++) cyc(1);
        check("phase gap", k, OSC_DIV);
        drive1 <= 1'b0;
        tie_en <= 1'b0;
        cyc(8);
        check("ss1 off", st1.soft_start, 1'b0);
        check("ss2 off", st2.soft_start, 1'b0);
    endtask
    task automatic t_seq2;
        restart(2'h2);
        check("mode", mode, DSS_MODE_2F);
        drive1 <= 1'b1;
        cyc(10);
        check("ss1 held", st1.soft_start, 1'b0);
        check("bias", bias_on, 1'b1);
        drive2 <= 1'b1;
        for (k = 0; k < 12 && st2.soft_start !== 1'b1; k++) cyc(1);
        check("ss2", st2.soft_start, 1'b1);
        check("ss1 waits", st1.soft_start, 1'b0);
        cyc(200);
        drive2 <= 1'b0;
        cyc(8);
        check("upper2", st2.upper_switch_on, 1'b0);
        check("upper1", st1.upper_switch_on, 1'b0);
        check("ss2 off", st2.soft_start, 1'b0);
    endtask
    task automatic t_seq1;
        restart(2'h1);
        check("mode", mode, DSS_MODE_1F);
        drive2 <= 1'b1;
        cyc(10);
        check("ss2 held", st2.soft_start, 1'b0);
        drive1 <= 1'b1;
        for (k = 0; k < 12 && st1.soft_start !== 1'b1; k++) cyc(1);
        for (k = 0; k < 60000 && st1.regulating !== 1'b1; k++) cyc(1);
        check("ramp len", (k - SS_STEPS * SS_STEP_CYC + 4) inside {[0:8]}, 1'b1);
        check("ref final", st1.reference, REF_FINAL);
        check("ss2 waits", st2.soft_start, 1'b0);
        for (k = 0; k < 12000 && st2.soft_start !== 1'b1; k++) cyc(1);
        check("delay", (k - SEQ_DELAY_CYC + 4) inside {[0:8]}, 1'b1);
        drive2 <= 1'b0;
        cyc(10);
        check("ss2 kept", st2.soft_start, 1'b1);
        drive1 <= 1'b0;
        cyc(8);
        check("upper1", st1.upper_switch_on, 1'b0);
        check("upper2", st2.upper_switch_on, 1'b0);
        check("ss2 stopped", st2.soft_start, 1'b0);
        check("reg1 stopped", st1.regulating, 1'b0);
        check("pulldown2", st2.pulldown_on, 1'b0);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        t_float();
        t_indep();
        t_ratio();
        t_seq2();
        t_seq1();
        tally_and_finish();
    end
    initial begin
        cyc(80000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
